// File: shared/ufimc_pkg.sv
package ufimc_pkg;
	// register byte addresses on the wishbone bus
	localparam logic [15:0] UFIMC_ADDR_CTL = 16'hFFFC;
	localparam logic [15:0] UFIMC_ADDR_MSK = 16'hFFFD;
	localparam logic [15:0] UFIMC_ADDR_STA = 16'hFFFE;
	// control register fields
	localparam int UFIMC_CTL_DIR = 0;
	localparam int UFIMC_CTL_SIR = 1;
	localparam int UFIMC_CTL_RSV3 = 3;
	localparam int UFIMC_CTL_FRST = 4;
	localparam int UFIMC_CTL_REMOTE_WAKE_PULSE_REQUEST = 5;
	localparam int UFIMC_CTL_INFRARED_MODE_SELECT = 6;
	localparam int UFIMC_CTL_UPSTREAM_PULLUP_ATTACH = 7;
	localparam logic [7:0] UFIMC_CTL_RST = 8'h10;
	// event / mask field positions
	localparam int UFIMC_EV_SETUP_OVERWRITE_EVENT = 0;
	localparam int UFIMC_EV_WAKE = 1;
	localparam int UFIMC_EV_SETUP = 2;
	localparam int UFIMC_EV_RING = 3;
	localparam int UFIMC_EV_RESUME = 5;
	localparam int UFIMC_EV_SUSPEND = 6;
	localparam int UFIMC_EV_PRST = 7;
	localparam logic [7:0] UFIMC_EV_IMPL = 8'hEF;
	localparam logic [7:0] UFIMC_MSK_RST = 8'h00;
	localparam logic [7:0] UFIMC_STA_RST = 8'h00;
	// remote wakeup pulse length in cycles
	localparam int UFIMC_WAKE_CYC = 1;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [15:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} ufimc_wb_req_s;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} ufimc_wb_rsp_s;

	typedef struct packed {
		logic data_in_dir;
		logic setup_service_active;
		logic infrared_mode_select;
		logic upstream_pullup_attach;
	} ufimc_ctl_out_s;
endpackage

// File: core/ufimc_sync.sv
`timescale 1ns/1ps
module ufimc_sync #(
	parameter int W = 8
) (
	input wire logic clk, // clock
	input wire logic nrst, // sync reset, active low
	input wire logic [W-1:0] d, // asynchronous inputs
	output logic [W-1:0] q // synchronised
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] q_ff;

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			meta_ff <= '0;
			q_ff <= '0;
		end
		else
		begin
			meta_ff <= d;
			q_ff <= meta_ff;
		end
	end

	assign q = q_ff;
endmodule

// File: core/ufimc_evt.sv
`timescale 1ns/1ps
module ufimc_evt
	import ufimc_pkg::*;
(
	input wire logic clk, // clock
	input wire logic nrst, // sync reset, active low
	input wire logic [7:0] evt, // synchronised event levels
	input wire logic [7:0] clr, // write-one-to-clear strobes
	output logic [7:0] flags // sticky flags
);
	logic [7:0] prev_ff;
	logic [7:0] flags_ff;
	logic [7:0] nxt_prev;
	logic [7:0] nxt_flags;

	// ****************************************
	// rising-edge capture, set wins over clear
	// ****************************************
	always_comb
	begin
		nxt_prev = evt;
		nxt_flags = ((flags_ff & ~clr) | (evt & ~prev_ff)) & UFIMC_EV_IMPL;
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			prev_ff <= '0;
			flags_ff <= UFIMC_STA_RST;
		end
		else
		begin
			prev_ff <= nxt_prev;
			flags_ff <= nxt_flags;
		end
	end

	assign flags = flags_ff;
endmodule

// File: core/ufimc_top.sv
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
// How it works
// - mask bit 0 enables the setup-overwrite interrupt
// - mask bit 1 enables the wakeup-pin request interrupt
// - mask bit 2 enables the setup-received interrupt
// - mask bit 3 enables the ring-indicate interrupt
// - mask bit 5 enables the function-resume interrupt
// - mask bit 6 enables the function-suspend interrupt
// - mask bit 7 enables port-reset interrupt and survives function reset
// - control register reset by power-up reset only, not bus reset
// - bit 4 resets to 1 and routes function reset to cpu reset
// - writing 1 to bit 5 emits one wake pulse, then clears
// - bit 6 picks infrared coding over plain uart
// - bit 7 enables the upstream pull-up
// - hardware sets event flags, firmware clears by writing one
// - setup flag high forces NAK on endpoint zero
module ufimc_top
	import ufimc_pkg::*;
(
	input wire logic clk, // 40 MHz clock
	input wire logic nrst, // power-up reset, sync, active low
	input wire logic func_rst, // usb function reset, same clock
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // wishbone write
	input wire logic [15:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte selects
	input wire logic [31:0] wb_dat_i, // write data
	output logic wb_ack_o, // acknowledge
	output logic [31:0] wb_dat_o, // read data
	input wire logic setup_overwrite_event, // overwrite level, async
	input wire logic wake_pin_event, // wake pin level, async
	input wire logic setup_rx_event, // setup received level, async
	input wire logic serial_incoming_call_event, // ring level, async
	input wire logic function_resume_event, // resume level, async
	input wire logic function_suspend_event, // suspend level, async
	input wire logic host_port_reset_event, // port reset level, async
	output logic irq, // function interrupt, level
	output logic ep0_force_nak, // NAK endpoint zero in and out
	output logic cpu_rst, // reset to microcontroller, active high
	output logic remote_wake_pulse, // one-cycle wake pulse upstream
	output ufimc_ctl_out_s ctl_o // control levels
);
	import ufimc_pkg::*;

	// ****************************************
	// event inputs
	// ****************************************
	logic [7:0] evt_raw;
	logic [7:0] evt_sync;
	logic [7:0] wr_clr;
	logic [7:0] flags;

	always_comb
	begin
		evt_raw = '0;
		evt_raw[UFIMC_EV_SETUP_OVERWRITE_EVENT] = setup_overwrite_event;
		evt_raw[UFIMC_EV_WAKE] = wake_pin_event;
		evt_raw[UFIMC_EV_SETUP] = setup_rx_event;
		evt_raw[UFIMC_EV_RING] = serial_incoming_call_event;
		evt_raw[UFIMC_EV_RESUME] = function_resume_event;
		evt_raw[UFIMC_EV_SUSPEND] = function_suspend_event;
		evt_raw[UFIMC_EV_PRST] = host_port_reset_event;
	end

	ufimc_sync #(.W(8)) u_sync (
		.clk(clk),
		.nrst(nrst),
		.d(evt_raw),
		.q(evt_sync)
	);

	ufimc_evt u_evt (
		.clk(clk),
		.nrst(nrst),
		.evt(evt_sync),
		.clr(wr_clr),
		.flags(flags)
	);

	// ****************************************
	// wishbone decode
	// ****************************************
	logic req;
	logic wr_lane0;
	logic ack_ff;
	logic nxt_ack;
	logic [31:0] rdat_ff;
	logic [31:0] nxt_rdat;
	logic hit_ctl;
	logic hit_msk;
	logic hit_sta;

	function automatic logic is_addr(input logic [15:0] a,
		input logic [15:0] r);
		// registers are byte wide and share one word; match the byte
		is_addr = (a == r);
	endfunction

	assign req = wb_cyc_i && wb_stb_i && !ack_ff;
	assign hit_ctl = is_addr(wb_adr_i, UFIMC_ADDR_CTL);
	assign hit_msk = is_addr(wb_adr_i, UFIMC_ADDR_MSK);
	assign hit_sta = is_addr(wb_adr_i, UFIMC_ADDR_STA);
	assign wr_lane0 = req && wb_we_i && wb_sel_i[0];
	assign wr_clr = (wr_lane0 && hit_sta) ? wb_dat_i[7:0] : 8'h00;

	// ****************************************
	// registers
	// ****************************************
	logic [7:0] ctl_ff;
	logic [7:0] nxt_ctl;
	logic [7:0] msk_ff;
	logic [7:0] nxt_msk;
	logic wake_ff;
	logic nxt_wake;

	function automatic logic [31:0] rd_word(input logic [7:0] b);
		// byte registers sit in the low lane, upper lanes read zero
		rd_word = {24'h000000, b};
	endfunction

	// ****************************************
	// bus answer
	// ****************************************
	// ack_ff also blocks a second take of the held request
	always_comb
	begin
		nxt_ack = req;
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			ack_ff <= 1'b0;
		end
		else
		begin
			ack_ff <= nxt_ack;
		end
	end

	always_comb
	begin
		nxt_rdat = 32'h0000_0000;
		if (req && !wb_we_i)
		begin
			if (hit_ctl)
				nxt_rdat = rd_word(ctl_ff);
			else if (hit_msk)
				nxt_rdat = rd_word(msk_ff);
			else if (hit_sta)
				nxt_rdat = rd_word(flags);
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			rdat_ff <= 32'h0000_0000;
		end
		else
		begin
			rdat_ff <= nxt_rdat;
		end
	end

	// ****************************************
	// control register
	// ****************************************
	always_comb
	begin
		nxt_ctl = ctl_ff;
		if (wr_lane0 && hit_ctl)
		begin
			nxt_ctl = wb_dat_i[7:0];
			nxt_ctl[UFIMC_CTL_RSV3] = 1'b0;
			nxt_ctl[2] = 1'b0;
			// wake bit is self-clearing: pulse only, never stored
			nxt_ctl[UFIMC_CTL_REMOTE_WAKE_PULSE_REQUEST] = 1'b0;
		end
	end

	// control register ignores func_rst by design
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			ctl_ff <= UFIMC_CTL_RST;
		end
		else
		begin
			ctl_ff <= nxt_ctl;
		end
	end

	// ****************************************
	// wake pulse
	// ****************************************
	always_comb
	begin
		nxt_wake = 1'b0;
		if (wr_lane0 && hit_ctl)
			nxt_wake = wb_dat_i[UFIMC_CTL_REMOTE_WAKE_PULSE_REQUEST];
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			wake_ff <= 1'b0;
		end
		else
		begin
			wake_ff <= nxt_wake;
		end
	end

	// ****************************************
	// mask register
	// ****************************************
	always_comb
	begin
		nxt_msk = msk_ff;
		if (wr_lane0 && hit_msk)
			nxt_msk = wb_dat_i[7:0] & UFIMC_EV_IMPL;
		if (func_rst)
		begin
			// only the port-reset enable outlives function reset
			nxt_msk = UFIMC_MSK_RST;
			nxt_msk[UFIMC_EV_PRST] = msk_ff[UFIMC_EV_PRST];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			msk_ff <= UFIMC_MSK_RST;
		end
		else
		begin
			msk_ff <= nxt_msk;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	logic irq_ff;
	logic nxt_irq;
	logic nak_ff;
	logic nxt_nak;
	logic cpu_rst_ff;
	logic nxt_cpu_rst;
	ufimc_ctl_out_s ctlo_ff;
	ufimc_ctl_out_s nxt_ctlo;

	// registered, so irq never glitches while flags and mask settle
	always_comb
	begin
		nxt_irq = |(flags & msk_ff & UFIMC_EV_IMPL);
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			irq_ff <= 1'b0;
		end
		else
		begin
			irq_ff <= nxt_irq;
		end
	end

	always_comb
	begin
		nxt_nak = flags[UFIMC_EV_SETUP];
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			nak_ff <= 1'b0;
		end
		else
		begin
			nak_ff <= nxt_nak;
		end
	end

	// one cycle late; a function reset lasts far longer than that
	always_comb
	begin
		nxt_cpu_rst = func_rst && ctl_ff[UFIMC_CTL_FRST];
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			cpu_rst_ff <= 1'b0;
		end
		else
		begin
			cpu_rst_ff <= nxt_cpu_rst;
		end
	end

	always_comb
	begin
		nxt_ctlo.data_in_dir = ctl_ff[UFIMC_CTL_DIR];
		nxt_ctlo.setup_service_active = ctl_ff[UFIMC_CTL_SIR];
		nxt_ctlo.infrared_mode_select = ctl_ff[UFIMC_CTL_INFRARED_MODE_SELECT];
		nxt_ctlo.upstream_pullup_attach = ctl_ff[UFIMC_CTL_UPSTREAM_PULLUP_ATTACH];
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			ctlo_ff <= '0;
		end
		else
		begin
			ctlo_ff <= nxt_ctlo;
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdat_ff;
	assign irq = irq_ff;
	assign ep0_force_nak = nak_ff;
	assign cpu_rst = cpu_rst_ff;
	assign remote_wake_pulse = wake_ff;
	assign ctl_o = ctlo_ff;
endmodule

// File: dv/ufimc_chk_sva.sv
`timescale 1ns/1ps
module ufimc_chk
	import ufimc_pkg::*;
(
	input wire logic clk, // clock
	input wire logic nrst, // power-up reset
	input wire logic func_rst, // function reset
	input wire logic wb_cyc_i, // cycle
	input wire logic wb_stb_i, // strobe
	input wire logic wb_we_i, // write
	input wire logic [15:0] wb_adr_i, // address
	input wire logic [3:0] wb_sel_i, // selects
	input wire logic [31:0] wb_dat_i, // write data
	input wire logic wb_ack_o, // ack
	input wire logic [31:0] wb_dat_o, // read data
	input wire logic setup_rx_event, // setup level
	input wire logic irq, // interrupt
	input wire logic ep0_force_nak, // nak
	input wire logic cpu_rst, // cpu reset
	input wire logic remote_wake_pulse, // wake
	input wire ufimc_pkg::ufimc_ctl_out_s ctl_o // control
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!nrst);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_wr(a);
		s_req ##0 wb_we_i && wb_sel_i[0] && wb_adr_i == a ##1 wb_ack_o;
	endsequence
	a_ack_next: assert property (s_req |=> wb_ack_o)
		else $error("ack missing");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held");
	a_mask_clear: assert property (
		s_wr(UFIMC_ADDR_MSK) ##0 wb_dat_i[7:0] == 8'h00 |-> ##2 !irq)
		else $error("irq with empty mask");
	a_wake_cause: assert property (
		s_wr(UFIMC_ADDR_CTL) ##0 wb_dat_i[5] |-> remote_wake_pulse)
		else $error("wake pulse missing");
	a_wake_only: assert property (
		remote_wake_pulse |-> wb_ack_o && wb_we_i
		&& wb_adr_i == UFIMC_ADDR_CTL)
		else $error("stray wake pulse");
	a_read_rsv: assert property (
		wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0
		&& (wb_adr_i != UFIMC_ADDR_CTL || (wb_dat_o[7:0] & 8'h2C) == 8'h00)
		&& (wb_adr_i != UFIMC_ADDR_MSK || !wb_dat_o[4]))
		else $error("reserved bit reads one");
	a_ctl_follow: assert property (
		s_wr(UFIMC_ADDR_CTL) |=> ctl_o == {$past(wb_dat_i[0]),
		$past(wb_dat_i[1]), $past(wb_dat_i[6]), $past(wb_dat_i[7])})
		else $error("control levels wrong");
	a_ctl_hold: assert property (
		(func_rst && !wb_stb_i) [*2] |=> $stable(ctl_o))
		else $error("function reset hit control");
	a_nak_setup: assert property (
		$rose(setup_rx_event) |-> ##[2:6] ep0_force_nak)
		else $error("no nak after setup");
	a_cpu_cause: assert property (cpu_rst |-> $past(func_rst))
		else $error("cpu reset without cause");
endmodule
bind ufimc_top ufimc_chk u_chk (
	.clk(clk),
	.nrst(nrst),
	.func_rst(func_rst),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i),
	.wb_ack_o(wb_ack_o),
	.wb_dat_o(wb_dat_o),
	.setup_rx_event(setup_rx_event),
	.irq(irq),
	.ep0_force_nak(ep0_force_nak),
	.cpu_rst(cpu_rst),
	.remote_wake_pulse(remote_wake_pulse),
	.ctl_o(ctl_o)
);

// File: dv/ufimc_host.sv
`timescale 1ns/1ps
module ufimc_host (
	input wire logic clk, // clock
	input wire logic attach, // pull-up on
	input wire logic wake, // wake pulse
	input wire logic [2:0] cmd, // resume, suspend, reset asks
	output logic resume, // resume level
	output logic suspend, // suspend level
	output logic port_reset // port reset level
);
	logic [2:0] cnt_ff = 3'h0;
	// host answers a wake pulse with a short resume
	always @(posedge clk)
		cnt_ff <= (wake && attach) ? 3'h7 : cnt_ff - 3'(cnt_ff != 3'h0);
	// a detached port sees no bus traffic at all
	assign resume = attach && (cmd[0] || cnt_ff != 3'h0);
	assign suspend = attach && cmd[1];
	assign port_reset = attach && cmd[2];
endmodule

// File: dv/ufimc_tb.sv
`timescale 1ns/1ps
module ufimc_tb;
	import ufimc_pkg::*;
	logic clk = 1'b0, nrst = 1'b0, func_rst = 1'b0, cyc = 1'b0, stb = 1'b0;
	logic we = 1'b0;
	logic [15:0] adr = 16'h0;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [7:0] ev = 8'h00;
	logic ack, irq, nak, cpu_rst, wake, h_res, h_sus, h_prst;
	logic [31:0] dout, rdat;
	logic [7:0] m;
	ufimc_ctl_out_s ctl;
	int err_count = 0;
	int check_count = 0;
	int wake_cnt = 0;
	always #12.5 clk = ~clk;
	ufimc_top dut (.clk(clk), .nrst(nrst), .func_rst(func_rst),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(dout),
		.setup_overwrite_event(ev[0]), .wake_pin_event(ev[1]),
		.setup_rx_event(ev[2]), .serial_incoming_call_event(ev[3]),
		.function_resume_event(h_res), .function_suspend_event(h_sus),
		.host_port_reset_event(h_prst), .irq(irq), .ep0_force_nak(nak),
		.cpu_rst(cpu_rst), .remote_wake_pulse(wake), .ctl_o(ctl));
	ufimc_host host (.clk(clk), .attach(ctl.upstream_pullup_attach),
		.wake(wake), .cmd(ev[7:5]), .resume(h_res), .suspend(h_sus),
		.port_reset(h_prst));
	always @(posedge clk)
		if (wake === 1'b1)
			wake_cnt++;
	// ****************
	// bus and checks
	// ****************
	task automatic chk(input logic [31:0] got, exp, input string nm);
		check_count++;
		if (got !== exp)
		begin
			$display("[ERR] %s exp %h got %h", nm, exp, got);
			err_count++;
		end
	endtask
	task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'h1;
		wdat <= {24'h0, d};
		// no cycle cap here: a hung bus is ended by the watchdog
		@(posedge clk);
		while (ack !== 1'b1)
			@(posedge clk);
		rdat = dout;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdc(input logic [15:0] a, input logic [7:0] e, string nm);
		wb(1'b0, a, 8'h00);
		chk(rdat, {24'h0, e}, nm);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge clk);
		err_count++;
		summarize();
	end
	initial
	begin
		void'($urandom(32'h0C5C));
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		rdc(UFIMC_ADDR_CTL, UFIMC_CTL_RST, "ctl");
		rdc(UFIMC_ADDR_MSK, UFIMC_MSK_RST, "msk");
		rdc(16'h1234, 8'h00, "hole");
		func_rst <= 1'b1;
		repeat (2) @(posedge clk);
		chk(cpu_rst, 1'b1, "cpu_rst");
		func_rst <= 1'b0;
		wb(1'b1, UFIMC_ADDR_CTL, 8'h80);
		wb(1'b1, UFIMC_ADDR_MSK, 8'hFF);
		rdc(UFIMC_ADDR_MSK, UFIMC_EV_IMPL, "msk impl");
		func_rst <= 1'b1;
		repeat (3) @(posedge clk);
		chk(cpu_rst, 1'b0, "cpu_rst off");
		func_rst <= 1'b0;
		rdc(UFIMC_ADDR_MSK, 8'h80, "msk kept");
		rdc(UFIMC_ADDR_CTL, 8'h80, "ctl kept");
		$display("test resets done");
		for (int i = 0; i < 8; i++)
			for (int k = 0; k < 2 && i != 4; k++)
			begin
				m = 8'($urandom) & ~(8'h01 << i) | (8'(k) << i);
				wb(1'b1, UFIMC_ADDR_MSK, m);
				ev[i] <= 1'b1;
				repeat (6) @(posedge clk);
				chk(irq, k, "irq");
				chk(nak, i == 2, "nak");
				ev <= 8'h00;
				rdc(UFIMC_ADDR_STA, 8'h01 << i, "flags");
				wb(1'b1, UFIMC_ADDR_STA, 8'h01 << i);
				repeat (2) @(posedge clk);
				chk({irq, nak}, 2'b00, "cleared");
			end
		$display("test events done");
		wb(1'b1, UFIMC_ADDR_CTL, 8'hE3);
		repeat (12) @(posedge clk);
		chk(wake_cnt, 1, "wake pulses");
		chk(ctl, 4'hF, "ctl_o");
		rdc(UFIMC_ADDR_STA, 8'h20, "resume");
		rdc(UFIMC_ADDR_CTL, 8'hC3, "ctl");
		wb(1'b1, UFIMC_ADDR_STA, 8'h20);
		wb(1'b1, UFIMC_ADDR_CTL, 8'h00);
		wb(1'b1, UFIMC_ADDR_MSK, 8'h00);
		@(posedge clk);
		chk(ctl, 4'h0, "ctl_o off");
		chk(wake_cnt, 1, "no wake on zero");
		$display("test control done");
		summarize();
	end
endmodule
